// ---- pkg/sdl_pkg.sv ----
// Constants and types shared by the SerDes lane-control register block
package sdl_pkg;
   localparam int SDL_NUM_SERDES = 8;
   localparam int SDL_NUM_LANES = 4;
   localparam int SDL_ADDR_W = 12;
   localparam int SDL_DATA_W = 32;
   localparam int SDL_TX_W = 6;
   localparam int SDL_SEL_W = 5;
   localparam int SDL_SERDES_IDX_W = 3;

   // Register map, one block of words per SerDes
   localparam logic [11:0] SDL_SERDES_STRIDE = 12'h020;
   localparam logic [11:0] SDL_OFS_CONTROL = 12'h000;
   localparam logic [11:0] SDL_OFS_TX_LANE_CTL0 = 12'h004;
   localparam logic [11:0] SDL_MAP_LIMIT = 12'h100;

   // Control register fields
   localparam int SDL_SEL_LSB = 0;
   localparam int SDL_SLEEP_BIT = 5;
   localparam logic [4:0] SDL_SEL_LANE_MAX = 5'h03;
   localparam logic [4:0] SDL_SEL_ALL = 5'h10;
   localparam logic [4:0] SDL_SEL_RESET = 5'h10;
   localparam logic SDL_SLEEP_RESET = 1'b0;

   // Transmit lane control 0 fields
   localparam int SDL_FULL_G1_LSB = 0;
   localparam int SDL_G2_3P5_LSB = 2;
   localparam int SDL_G2_6P0_LSB = 4;
   localparam logic [1:0] SDL_FULL_G1_RESET = 2'h2;
   localparam logic [1:0] SDL_G2_3P5_RESET = 2'h3;
   localparam logic [1:0] SDL_G2_6P0_RESET = 2'h2;
   localparam logic [5:0] SDL_TX_RESET = {SDL_G2_6P0_RESET, SDL_G2_3P5_RESET, SDL_FULL_G1_RESET};

   // Power-up initialisation time of the SerDes
   localparam int SDL_CLK_PERIOD_PS = 4000;
   localparam int SDL_INIT_TIME_NS = 64;
   localparam int SDL_INIT_CYCLES = (SDL_INIT_TIME_NS * 1000 + SDL_CLK_PERIOD_PS - 1)
      / SDL_CLK_PERIOD_PS;
   localparam int SDL_INIT_CNT_W = 8;

   typedef enum logic [1:0] {
      SDL_PWR_ON = 2'b00,
      SDL_PWR_DOWN = 2'b01,
      SDL_PWR_INIT = 2'b10
   } sdl_pwr_state_t;
endpackage

// ---- pkg/sdl_lane_if.sv ----
// Link between the register block and one SerDes's lane storage
interface sdl_lane_if #(parameter int NUM_LANES = sdl_pkg::SDL_NUM_LANES);
   logic wr_tx;
   logic [sdl_pkg::SDL_TX_W-1:0] wdata_tx;
   logic [sdl_pkg::SDL_SEL_W-1:0] lane_sel;
   logic gen2;
   logic deemph_choice;
   logic low_swing;
   logic [sdl_pkg::SDL_TX_W-1:0] rd_tx;
   logic [2*NUM_LANES-1:0] fine;
   logic [NUM_LANES-1:0] deemph_en;

   modport regs (output wr_tx, wdata_tx, lane_sel, gen2, deemph_choice, low_swing,
      input rd_tx, fine, deemph_en);
   modport store (input wr_tx, wdata_tx, lane_sel, gen2, deemph_choice, low_swing,
      output rd_tx, fine, deemph_en);
endinterface

// ---- core/sdl_lane_store.sv ----
// Per-lane storage of transmit fine de-emphasis settings for one SerDes
module sdl_lane_store #(
   parameter int NUM_LANES = sdl_pkg::SDL_NUM_LANES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register side
   sdl_lane_if.store lif
);
   import sdl_pkg::*;

   logic [SDL_TX_W-1:0] lane_ff [NUM_LANES];
   logic [SDL_TX_W-1:0] shadow_ff;
   logic [2*NUM_LANES-1:0] fine_ff;
   logic [NUM_LANES-1:0] en_ff;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int l = 0; l < NUM_LANES; l++)
            lane_ff[l] <= SDL_TX_RESET;
      end
      else if (lif.wr_tx)
      begin
         for (int l = 0; l < NUM_LANES; l++)
         begin
            if (lif.lane_sel == SDL_SEL_ALL || lif.lane_sel == SDL_SEL_W'(l))
               lane_ff[l] <= lif.wdata_tx;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         shadow_ff <= SDL_TX_RESET;
      else if (lif.wr_tx)
         shadow_ff <= lif.wdata_tx;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         fine_ff <= '0;
         en_ff <= '0;
      end
      else
      begin
         for (int l = 0; l < NUM_LANES; l++)
         begin
            en_ff[l] <= !lif.low_swing;
            if (lif.low_swing)
               fine_ff[2*l +: 2] <= 2'h0;
            else if (!lif.gen2)
               fine_ff[2*l +: 2] <= lane_ff[l][SDL_FULL_G1_LSB +: 2];
            else if (lif.deemph_choice)
               fine_ff[2*l +: 2] <= lane_ff[l][SDL_G2_3P5_LSB +: 2];
            else
               fine_ff[2*l +: 2] <= lane_ff[l][SDL_G2_6P0_LSB +: 2];
         end
      end
   end

   assign lif.rd_tx = shadow_ff;
   assign lif.fine = fine_ff;
   assign lif.deemph_en = en_ff;
endmodule // sdl_lane_store

// ---- core/sdl_lane_ctrl_regs.sv ----
// APB register bank for SerDes lane control and deep power-down
//
// What this block does
// - Lane-select field picks the lane that lane-control writes go to.
// - Codes 0 to 3 pick one lane; 0x10, the default, picks all lanes.
// - A single-lane write changes only that lane's stored setting.
// - Reads of lane-control registers ignore the lane-select field.
// - A read returns the last value written, whatever lane it went to.
// - Power-down puts every lane in P2 and turns the clock multiplier off.
// - Setting power-down sends each associated link machine to Detect at once.
// - Clearing power-down powers up, initialises, then starts link training.
// - Power-down bit does nothing to a SerDes already powered down; during initialisation the bit still powers it down.
// - Two-bit full-swing first-generation fine de-emphasis field, reset 0x2.
// - Two-bit second-generation minus 3.5 dB fine field, reset 0x3.
// - Two-bit second-generation minus 6.0 dB fine field, reset 0x2.
// - Fine de-emphasis fields are ignored in low-swing mode.
// - Lane settings survive ordinary resets on every lane.
//
// The implementer's own choices: the APB slave port and the register offsets.
module sdl_lane_ctrl_regs
   import sdl_pkg::*;
#(
   parameter int NUM_SERDES = sdl_pkg::SDL_NUM_SERDES,
   parameter int NUM_LANES = sdl_pkg::SDL_NUM_LANES
) (
   // Clock and resets
   input wire logic mclk,
   input wire logic rst,
   input wire logic soft_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sdl_pkg::SDL_ADDR_W-1:0] paddr,
   input wire logic [sdl_pkg::SDL_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [sdl_pkg::SDL_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port status per SerDes
   input wire logic [NUM_SERDES-1:0] serdes_already_down,
   input wire logic [NUM_SERDES-1:0] gen2_rate,
   input wire logic [NUM_SERDES-1:0] deemph_level_choice,
   input wire logic [NUM_SERDES-1:0] low_swing,
   // Power control per SerDes
   output logic [NUM_SERDES-1:0] lanes_in_p2,
   output logic [NUM_SERDES-1:0] clock_multiplier_unit_off,
   output logic [NUM_SERDES-1:0] ltssm_to_detect,
   output logic [NUM_SERDES-1:0] ltssm_start_training,
   // Transmit de-emphasis per lane
   output logic [2*NUM_SERDES*NUM_LANES-1:0] tx_fine_deemph,
   output logic [NUM_SERDES*NUM_LANES-1:0] tx_deemph_en
);
   import sdl_pkg::*;

   if (NUM_SERDES < 1 || NUM_SERDES > SDL_NUM_SERDES)
      $error("NUM_SERDES out of range");
   if (NUM_LANES < 1 || NUM_LANES > SDL_NUM_LANES)
      $error("NUM_LANES out of range");
   if (SDL_INIT_CYCLES < 1 || SDL_INIT_CYCLES > 2 ** SDL_INIT_CNT_W)
      $error("Init time does not fit its counter");

   typedef struct packed {
      logic hit;
      logic is_tx;
      logic [SDL_SERDES_IDX_W-1:0] idx;
   } sdl_decode_t;

   // Address decode shared by reads and writes
   function automatic sdl_decode_t sdl_decode(input logic [SDL_ADDR_W-1:0] addr);
      sdl_decode_t d;
      logic [SDL_ADDR_W-1:0] ofs;
      d = '0;
      ofs = addr & (SDL_SERDES_STRIDE - 12'h001);
      d.idx = addr[5 +: SDL_SERDES_IDX_W];
      // Slots above the instantiated SerDes count decode as misses
      if (addr >= SDL_MAP_LIMIT || 32'(d.idx) >= NUM_SERDES)
         d.hit = 1'b0;
      else if (ofs == SDL_OFS_CONTROL)
         d.hit = 1'b1;
      else if (ofs == SDL_OFS_TX_LANE_CTL0)
      begin
         d.hit = 1'b1;
         d.is_tx = 1'b1;
      end
      else
         d.hit = 1'b0;
      return d;
   endfunction

   logic [SDL_DATA_W-1:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [SDL_SEL_W-1:0] lane_sel_ff [NUM_SERDES];
   logic [NUM_SERDES-1:0] sleep_ff;
   sdl_pwr_state_t pwr_ff [NUM_SERDES];
   logic [SDL_INIT_CNT_W-1:0] init_cnt_ff [NUM_SERDES];
   logic [NUM_SERDES-1:0] p2_ff;
   logic [NUM_SERDES-1:0] cmu_off_ff;
   logic [NUM_SERDES-1:0] detect_ff;
   logic [NUM_SERDES-1:0] train_ff;
   logic [2*NUM_SERDES*NUM_LANES-1:0] fine_ff;
   logic [NUM_SERDES*NUM_LANES-1:0] en_ff;

   sdl_decode_t dec;
   logic access;
   logic wr_done;
   logic [SDL_DATA_W-1:0] nxt_prdata;
   logic [SDL_TX_W-1:0] rd_tx [NUM_SERDES];
   logic [2*NUM_LANES-1:0] lane_fine [NUM_SERDES];
   logic [NUM_LANES-1:0] lane_en [NUM_SERDES];

   assign dec = sdl_decode(paddr);
   assign access = psel && penable;
   // Write lands only on the completing edge
   assign wr_done = access && pready_ff && pwrite && pstrb[0] && dec.hit;

   // One wait state: answer is ready on the second access cycle
   // Ready clears itself the cycle after it rises, even while access is still high
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pready_ff <= 1'b0;
      else if (soft_rst)
         pready_ff <= 1'b0;
      else
         pready_ff <= access && !pready_ff;
   end

   always_comb
   begin
      nxt_prdata = '0;
      if (!dec.hit)
         nxt_prdata = '0;
      else if (dec.is_tx)
         nxt_prdata[SDL_TX_W-1:0] = rd_tx[dec.idx];
      else
      begin
         nxt_prdata[SDL_SEL_LSB +: SDL_SEL_W] = lane_sel_ff[dec.idx];
         nxt_prdata[SDL_SLEEP_BIT] = sleep_ff[dec.idx];
      end
   end

   // Read data stands only in the completing cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         prdata_ff <= '0;
      else if (soft_rst)
         prdata_ff <= '0;
      else if (access && !pready_ff)
         prdata_ff <= pwrite ? '0 : nxt_prdata;
      else
         prdata_ff <= '0;
   end

   // Unmapped words answer with an error
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pslverr_ff <= 1'b0;
      else if (soft_rst)
         pslverr_ff <= 1'b0;
      else if (access && !pready_ff)
         pslverr_ff <= !dec.hit;
      else
         pslverr_ff <= 1'b0;
   end

   // Sticky: only the power-on reset clears it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int s = 0; s < NUM_SERDES; s++)
            lane_sel_ff[s] <= SDL_SEL_RESET;
      end
      else if (wr_done && !dec.is_tx)
      begin
         lane_sel_ff[dec.idx] <= pwdata[SDL_SEL_LSB +: SDL_SEL_W];
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int s = 0; s < NUM_SERDES; s++)
            sleep_ff[s] <= SDL_SLEEP_RESET;
      end
      else if (wr_done && !dec.is_tx)
         sleep_ff[dec.idx] <= pwdata[SDL_SLEEP_BIT];
   end

   // Power sequencing per SerDes
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int s = 0; s < NUM_SERDES; s++)
         begin
            pwr_ff[s] <= SDL_PWR_ON;
         end
         p2_ff <= '0;
         cmu_off_ff <= '0;
         detect_ff <= '0;
         train_ff <= '0;
      end
      else
      begin
         for (int s = 0; s < NUM_SERDES; s++)
         begin
            detect_ff[s] <= 1'b0;
            train_ff[s] <= 1'b0;
            case (pwr_ff[s])
               SDL_PWR_ON:
               begin
                  // Already down: no effect
                  // Bit stays pending until the port is up again
                  if (sleep_ff[s] && !serdes_already_down[s])
                  begin
                     pwr_ff[s] <= SDL_PWR_DOWN;
                     p2_ff[s] <= 1'b1;
                     cmu_off_ff[s] <= 1'b1;
                     detect_ff[s] <= 1'b1;
                  end
               end
               SDL_PWR_DOWN:
               begin
                  if (!sleep_ff[s] && !serdes_already_down[s])
                  begin
                     pwr_ff[s] <= SDL_PWR_INIT;
                     p2_ff[s] <= 1'b0;
                     cmu_off_ff[s] <= 1'b0;
                  end
               end
               SDL_PWR_INIT:
               begin
                  if (sleep_ff[s])
                  begin
                     pwr_ff[s] <= SDL_PWR_DOWN;
                     p2_ff[s] <= 1'b1;
                     cmu_off_ff[s] <= 1'b1;
                     detect_ff[s] <= 1'b1;
                  end
                  else if (init_cnt_ff[s] == '0)
                  begin
                     pwr_ff[s] <= SDL_PWR_ON;
                     train_ff[s] <= 1'b1;
                  end
               end
               default:
                  pwr_ff[s] <= SDL_PWR_ON;
            endcase
         end
      end
   end

   // Initialisation timer, loaded while powered down
   // Reloading in DOWN lets an aborted start begin afresh
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int s = 0; s < NUM_SERDES; s++)
            init_cnt_ff[s] <= '0;
      end
      else
      begin
         for (int s = 0; s < NUM_SERDES; s++)
         begin
            if (pwr_ff[s] == SDL_PWR_DOWN)
               init_cnt_ff[s] <= SDL_INIT_CNT_W'(SDL_INIT_CYCLES - 1);
            else if (pwr_ff[s] == SDL_PWR_INIT && init_cnt_ff[s] != '0)
               init_cnt_ff[s] <= init_cnt_ff[s] - 1'b1;
         end
      end
   end

   // Per-SerDes lane storage
   for (genvar s = 0; s < NUM_SERDES; s++)
   begin : g_serdes
      sdl_lane_if #(.NUM_LANES(NUM_LANES)) lif ();

      assign lif.wr_tx = wr_done && dec.is_tx && dec.idx == SDL_SERDES_IDX_W'(s);
      assign lif.wdata_tx = pwdata[SDL_TX_W-1:0];
      assign lif.lane_sel = lane_sel_ff[s];
      assign lif.gen2 = gen2_rate[s];
      assign lif.deemph_choice = deemph_level_choice[s];
      assign lif.low_swing = low_swing[s];
      assign rd_tx[s] = lif.rd_tx;
      assign lane_fine[s] = lif.fine;
      assign lane_en[s] = lif.deemph_en;

      sdl_lane_store #(.NUM_LANES(NUM_LANES)) u_store (
         .mclk(mclk),
         .rst(rst),
         .lif(lif)
      );
   end

   // Output stage keeps every port on a flop
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         fine_ff <= '0;
         en_ff <= '0;
      end
      else
      begin
         for (int s = 0; s < NUM_SERDES; s++)
         begin
            fine_ff[2*NUM_LANES*s +: 2*NUM_LANES] <= lane_fine[s];
            en_ff[NUM_LANES*s +: NUM_LANES] <= lane_en[s];
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign lanes_in_p2 = p2_ff;
   assign clock_multiplier_unit_off = cmu_off_ff;
   assign ltssm_to_detect = detect_ff;
   assign ltssm_start_training = train_ff;
   assign tx_fine_deemph = fine_ff;
   assign tx_deemph_en = en_ff;
endmodule // sdl_lane_ctrl_regs

// ---- dv/sdl_lane_ctrl_props_properties.sv ----
// Bus and power-control properties of the lane-control register bank
module sdl_lane_ctrl_props #(
   parameter int NUM_SERDES = 8,
   parameter int NUM_LANES = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [sdl_pkg::SDL_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Power and de-emphasis
   input wire logic [NUM_SERDES-1:0] serdes_already_down,
   input wire logic [NUM_SERDES-1:0] low_swing,
   input wire logic [NUM_SERDES-1:0] lanes_in_p2,
   input wire logic [NUM_SERDES-1:0] clock_multiplier_unit_off,
   input wire logic [NUM_SERDES-1:0] ltssm_to_detect,
   input wire logic [NUM_SERDES-1:0] ltssm_start_training,
   input wire logic [2*NUM_SERDES*NUM_LANES-1:0] tx_fine_deemph,
   input wire logic [NUM_SERDES*NUM_LANES-1:0] tx_deemph_en
);
   import sdl_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_ready_one_wait: assert property ($rose(psel && penable) |=> pready)
      else $error("ready not one cycle after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("ready without request");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error outside completion");
   a_rdata_idle: assert property (!pready |-> prdata == '0)
      else $error("read data outside completion");
   a_p2_cmu_pair: assert property (lanes_in_p2 == clock_multiplier_unit_off)
      else $error("p2 and clock multiplier disagree");
   a_detect_on_entry: assert property (
      ltssm_to_detect == (lanes_in_p2 & ~$past(lanes_in_p2)))
      else $error("detect pulse not tied to power-down entry");
   a_down_no_entry: assert property (
      (lanes_in_p2 & $past(serdes_already_down & ~lanes_in_p2)) == '0)
      else $error("entered power-down while already down");
   a_down_no_exit: assert property (
      (~lanes_in_p2 & $past(serdes_already_down & lanes_in_p2)) == '0)
      else $error("left power-down while already down");
   a_train_after_init: assert property (
      $fell(lanes_in_p2[4]) |-> ##[16:18] ltssm_start_training[4])
      else $error("training did not start after init");
   a_low_swing_off: assert property (
      low_swing[2] && $past(low_swing[2]) && $past(low_swing[2], 2)
      |-> tx_deemph_en[11:8] == '0 && tx_fine_deemph[23:16] == '0)
      else $error("de-emphasis active in low swing");
endmodule // sdl_lane_ctrl_props

// ---- dv/sdl_lane_ctrl_regs_tb.sv ----
// Self-checking bench for the lane-control register bank
module sdl_lane_ctrl_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sdl_pkg::*;
   logic mclk, rst, soft_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, den;
   logic [3:0] pstrb;
   logic [7:0] down, gen2, choice, lsw, p2, clock_multiplier_unit, det, trn;
   logic [63:0] fine;
   int failures, num_checks, n;

   sdl_lane_ctrl_regs i_dut (.mclk(mclk), .rst(rst), .soft_rst(soft_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .serdes_already_down(down),
      .gen2_rate(gen2), .deemph_level_choice(choice), .low_swing(lsw), .lanes_in_p2(p2),
      .clock_multiplier_unit_off(clock_multiplier_unit), .ltssm_to_detect(det), .ltssm_start_training(trn),
      .tx_fine_deemph(fine), .tx_deemph_en(den));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic stop_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [11:0] ad(input int s, input logic [11:0] ofs);
      return SDL_SERDES_STRIDE * s[11:0] + ofs;
   endfunction

   // Request held until the edge that samples ready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
      begin
         failures++;
         $display("[ERR] %0t no ready", $time);
         stop_test();
      end
      // Answer taken at the edge that samples ready
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Outputs lag two flop stages
   task automatic settle;
      repeat (3) @(negedge mclk);
   endtask

   task automatic wait_pulse(input bit train);
      n = 0;
      do
      begin
         @(negedge mclk);
         n++;
      end while ((train ? trn[4] : det[4]) !== 1'b1 && n < 40);
      if ((train ? trn[4] : det[4]) !== 1'b1)
      begin
         failures++;
         $display("[ERR] %0t no pulse", $time);
         stop_test();
      end
   endtask

   task automatic t_reset;
      apb(1'b0, ad(0, SDL_OFS_CONTROL), 32'h0);
      chk(rd, 32'h10);
      apb(1'b0, ad(3, SDL_OFS_TX_LANE_CTL0), 32'h0);
      chk(rd, 32'h2e);
      chk(fine[31:0], 32'haaaaaaaa);
      chk(den, 32'hffffffff);
      apb(1'b1, 12'h100, 32'h5);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, ad(7, SDL_OFS_TX_LANE_CTL0), 32'hffffffc1);
      apb(1'b0, ad(7, SDL_OFS_TX_LANE_CTL0), 32'h0);
      chk(rd, 32'h01);
      apb(1'b1, ad(7, SDL_OFS_CONTROL), 32'hffffffd0);
      apb(1'b0, ad(7, SDL_OFS_CONTROL), 32'h0);
      chk(rd, 32'h10);
      // Write without byte 0 strobe is dropped
      @(posedge mclk);
      pstrb <= 4'he;
      apb(1'b1, ad(7, SDL_OFS_CONTROL), 32'h00000003);
      pstrb <= 4'hf;
      apb(1'b0, ad(7, SDL_OFS_CONTROL), 32'h0);
      chk(rd, 32'h10);
   endtask

   task automatic t_lanes;
      // Only lane codes 0 to 3 and broadcast are programmed
      for (int l = 0; l < 4; l++)
      begin
         apb(1'b1, ad(2, SDL_OFS_CONTROL), l);
         apb(1'b1, ad(2, SDL_OFS_TX_LANE_CTL0), l);
      end
      settle();
      chk(fine[23:16], 8'he4);
      chk(fine[15:8], 8'haa);
      apb(1'b0, ad(2, SDL_OFS_TX_LANE_CTL0), 32'h0);
      chk(rd, 32'h03);
      apb(1'b1, ad(2, SDL_OFS_CONTROL), 32'h10);
      apb(1'b1, ad(2, SDL_OFS_TX_LANE_CTL0), 32'h24);
      settle();
      chk(fine[23:16], 8'h00);
   endtask

   task automatic t_gen2;
      @(posedge mclk);
      gen2 <= 8'h04;
      choice <= 8'h04;
      settle();
      chk(fine[23:16], 8'h55);
      @(posedge mclk);
      choice <= 8'h00;
      settle();
      chk(fine[23:16], 8'haa);
      @(posedge mclk);
      lsw <= 8'h04;
      settle();
      chk({den[11:8], fine[23:16]}, 32'h0);
      @(posedge mclk);
      lsw <= 8'h00;
      gen2 <= 8'h00;
   endtask

   task automatic t_power;
      apb(1'b1, ad(4, SDL_OFS_CONTROL), 32'h30);
      wait_pulse(1'b0);
      chk(n, 2);
      chk({p2[4], clock_multiplier_unit[4]}, 2'b11);
      apb(1'b1, ad(4, SDL_OFS_CONTROL), 32'h10);
      wait_pulse(1'b1);
      chk(n > 14 && n < 22, 1'b1);
      chk({p2[4], clock_multiplier_unit[4]}, 2'b00);
      @(posedge mclk);
      down <= 8'h20;
      apb(1'b1, ad(5, SDL_OFS_CONTROL), 32'h30);
      settle();
      chk({p2[5], det[5]}, 2'b00);
      apb(1'b1, ad(5, SDL_OFS_CONTROL), 32'h10);
      @(posedge mclk);
      down <= 8'h00;
   endtask

   // Ordinary reset must leave stored settings alone
   task automatic t_soft;
      @(posedge mclk);
      soft_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      soft_rst <= 1'b0;
      apb(1'b0, ad(2, SDL_OFS_TX_LANE_CTL0), 32'h0);
      chk(rd, 32'h24);
      chk(fine[63:56], 8'h55);
   endtask

   initial
   begin
      rst = 1'b1;
      soft_rst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      down = '0;
      gen2 = '0;
      choice = '0;
      lsw = '0;
      failures = 0;
      num_checks = 0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_lanes();
      t_gen2();
      t_power();
      t_soft();
      stop_test();
   end
endmodule // sdl_lane_ctrl_regs_tb

bind sdl_lane_ctrl_regs sdl_lane_ctrl_props #(.NUM_SERDES(NUM_SERDES), .NUM_LANES(NUM_LANES))
   i_props (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serdes_already_down(serdes_already_down),
   .low_swing(low_swing), .lanes_in_p2(lanes_in_p2),
   .clock_multiplier_unit_off(clock_multiplier_unit_off), .ltssm_to_detect(ltssm_to_detect),
   .ltssm_start_training(ltssm_start_training), .tx_fine_deemph(tx_fine_deemph),
   .tx_deemph_en(tx_deemph_en));
